// >>> src/spics_pkg.sv
// Overview of operation
// [R01] slave mode needs rate source and divide 1
// [R02] master inverts frame output to active-low enable
// [R03] slave inverts active-low frame inputs internally
// [R04] master: tx clock/frame driven, rx ones 0
// [R05] slave: all four direction bits are 0
// [R06] enable low before first clock edge
// [R07] clock period is divide plus one cycles (divide 0 gives two)
// [R08] low phase half, or divide/2 when even
// [R09] high phase half, or divide/2+1 when even
// [R10] timing from cpu clock, no output divider
// [R11] stop 10b, polarity 1: sample rising edge
// [R12] stop 11b, polarity 1: sample falling edge
// [R13] slave releases data line when enable high
// [R14] stop 10b, polarity 0: sample falling edge
// [R15] master raises enable, stops clock after word
package spics_pkg;

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam int unsigned DIV_W           = 8;
    localparam int unsigned CNT_W           = 9;
    localparam logic        SLAVE_RATE_SRC  = 1'b1;
    localparam logic [7:0]  SLAVE_RATE_DIV  = 8'h01;
    localparam logic [7:0]  DIV_ZERO        = 8'h00;
    localparam logic [8:0]  CNT_ONE         = 9'h001;
    localparam int unsigned STOP_ENABLE_BIT = 1;
    localparam int unsigned STOP_DELAY_BIT  = 0;
    localparam int unsigned SYNC_W          = 4;
    localparam int unsigned SY_CLK          = 3;
    localparam int unsigned SY_TXFS         = 2;
    localparam int unsigned SY_RXFS         = 1;
    localparam int unsigned SY_RXD          = 0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]       clock_stop_phase_select;
        logic             tx_clock_polarity;
        logic             rate_gen_clock_source;
        logic [DIV_W-1:0] rate_gen_divide_value;
        logic             rx_frame_polarity;
        logic             tx_frame_polarity;
        logic             tx_clock_direction;
        logic             rx_clock_direction;
        logic             tx_frame_direction;
        logic             rx_frame_direction;
    } spics_cfg_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LEAD,
        ST_SHIFT,
        ST_TRAIL,
        ST_SLAVE
    } spics_state_t;

endpackage : spics_pkg

// >>> src/spics_port.sv
`timescale 1ns/1ns
`default_nettype none
module spics_port #(
    parameter int unsigned WORD_W = 8
) (
    input  wire logic                   mclk_i,
    input  wire logic                   nrst_i,
    input  wire spics_pkg::spics_cfg_t  cfg_i,
    input  wire logic [WORD_W-1:0]      tx_data_i,
    input  wire logic                   tx_valid_i,
    output logic                        tx_ready_o,
    output logic [WORD_W-1:0]           rx_data_o,
    output logic                        rx_valid_o,
    output logic                        mode_error_o,
    input  wire logic                   serial_bit_clock_pin_i,
    output logic                        serial_bit_clock_pin_o,
    output logic                        serial_bit_clock_pin_oe_o,
    input  wire logic                   tx_frame_pin_i,
    output logic                        tx_frame_pin_o,
    output logic                        tx_frame_pin_oe_o,
    input  wire logic                   rx_frame_pin_i,
    output logic                        serial_tx_data_pin_o,
    output logic                        serial_tx_data_pin_oe_o,
    input  wire logic                   serial_rx_data_pin_i
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    localparam int unsigned EDGE_W = $clog2(2 * WORD_W) + 1;
    localparam int unsigned BIT_W  = $clog2(WORD_W + 1);
    localparam logic [EDGE_W-1:0] LAST_EDGE = EDGE_W'(2 * WORD_W - 1);
    localparam logic [BIT_W-1:0]  LAST_BIT  = BIT_W'(WORD_W - 1);

    generate
        if (WORD_W < 2 || WORD_W > 32) begin : g_bad_width
            $error("spics_port: WORD_W must be 2 to 32");
        end
    endgenerate

    // ------------------------------------------------------------
    // phase length decode
    // ------------------------------------------------------------
    // divide 0 would ask for a one-cycle period; it is clamped to two
    function automatic logic [spics_pkg::CNT_W-1:0] phase_len(
        input logic [spics_pkg::DIV_W-1:0] div,
        input logic                        level
    );
        logic [spics_pkg::CNT_W-1:0] period;
        logic [spics_pkg::CNT_W-1:0] low;
        period = {1'b0, div} + spics_pkg::CNT_ONE;
        // [R08] low phase length
        if (div == spics_pkg::DIV_ZERO) begin
            low = spics_pkg::CNT_ONE;
        end else if (div[0]) begin
            low = period >> 1;
        end else begin
            low = {2'b00, div[spics_pkg::DIV_W-1:1]};
        end
        // [R09] high phase length
        if (!level) begin
            phase_len = low;
        end else if (div == spics_pkg::DIV_ZERO) begin
            phase_len = spics_pkg::CNT_ONE;
        end else begin
            phase_len = period - low;
        end
    endfunction : phase_len

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    logic is_master;
    logic is_slave;
    logic slave_rate_ok;
    logic stop_on;
    logic sample_rise;
    logic master_ok;
    logic slave_ok;

    // [R04] master direction bits
    assign is_master = cfg_i.tx_clock_direction & cfg_i.tx_frame_direction &
                       ~cfg_i.rx_clock_direction & ~cfg_i.rx_frame_direction;
    // [R05] slave direction bits
    assign is_slave  = ~cfg_i.tx_clock_direction & ~cfg_i.tx_frame_direction &
                       ~cfg_i.rx_clock_direction & ~cfg_i.rx_frame_direction;
    // [R01] slave rate check
    assign slave_rate_ok = (cfg_i.rate_gen_clock_source == spics_pkg::SLAVE_RATE_SRC) &&
                           (cfg_i.rate_gen_divide_value == spics_pkg::SLAVE_RATE_DIV);
    assign stop_on   = cfg_i.clock_stop_phase_select[spics_pkg::STOP_ENABLE_BIT];
    // [R11] [R12] [R14] sampling edge select
    assign sample_rise = cfg_i.tx_clock_polarity ^
                         cfg_i.clock_stop_phase_select[spics_pkg::STOP_DELAY_BIT];
    assign master_ok = stop_on & is_master;
    assign slave_ok  = stop_on & is_slave & slave_rate_ok;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [spics_pkg::SYNC_W-1:0] s1_q, s1_d;
    logic [spics_pkg::SYNC_W-1:0] s2_q, s2_d;
    logic [spics_pkg::SYNC_W-1:0] s3_q, s3_d;

    always_comb begin
        s1_d = {serial_bit_clock_pin_i, tx_frame_pin_i, rx_frame_pin_i, serial_rx_data_pin_i};
        s2_d = s1_q;
        s3_d = s2_q;
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end

    logic fs_tx_in;
    logic fs_rx_in;
    logic slave_fs;
    logic slave_edge;
    logic rxd_in;

    // [R03] active-low enables inverted
    assign fs_tx_in   = s2_q[spics_pkg::SY_TXFS] ^ cfg_i.tx_frame_polarity;
    assign fs_rx_in   = s2_q[spics_pkg::SY_RXFS] ^ cfg_i.rx_frame_polarity;
    assign slave_fs   = fs_tx_in | fs_rx_in;
    assign slave_edge = s2_q[spics_pkg::SY_CLK] ^ s3_q[spics_pkg::SY_CLK];
    assign rxd_in     = s2_q[spics_pkg::SY_RXD];

    // ------------------------------------------------------------
    // transfer engine
    // ------------------------------------------------------------
    spics_pkg::spics_state_t      state_q, state_d;
    logic [spics_pkg::CNT_W-1:0]  cnt_q, cnt_d;
    logic [EDGE_W-1:0]            edges_q, edges_d;
    logic [BIT_W-1:0]             bits_q, bits_d;
    logic [WORD_W-1:0]            tsh_q, tsh_d;
    logic [WORD_W-1:0]            rsh_q, rsh_d;
    logic [WORD_W-1:0]            rdat_q, rdat_d;
    logic                         rval_q, rval_d;
    logic                         sck_q, sck_d;
    logic                         fs_q, fs_d;
    logic                         dout_q, dout_d;
    logic                         doe_q, doe_d;
    logic                         err_q, err_d;
    logic                         edge_hit;
    logic                         edge_rise;
    logic                         phase_done;

    assign tx_ready_o = (state_q == spics_pkg::ST_IDLE) & (master_ok | (slave_ok & slave_fs));
    // [R07] [R10] phase counted on mclk only
    assign phase_done = (cnt_q + spics_pkg::CNT_ONE) >=
                        phase_len(cfg_i.rate_gen_divide_value, sck_q);

    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        edges_d   = edges_q;
        bits_d    = bits_q;
        tsh_d     = tsh_q;
        rsh_d     = rsh_q;
        rdat_d    = rdat_q;
        rval_d    = 1'b0;
        sck_d     = sck_q;
        fs_d      = fs_q;
        dout_d    = dout_q;
        doe_d     = doe_q;
        err_d     = stop_on & ~master_ok & ~slave_ok;
        edge_hit  = 1'b0;
        edge_rise = 1'b0;
        case (state_q)
            spics_pkg::ST_IDLE: begin
                sck_d = cfg_i.tx_clock_polarity;
                cnt_d = '0;
                edges_d = '0;
                bits_d = '0;
                if (master_ok && tx_valid_i) begin
                    // [R06] enable asserted before clocking
                    fs_d    = 1'b1;
                    doe_d   = 1'b1;
                    tsh_d   = tx_data_i;
                    dout_d  = tx_data_i[WORD_W-1];
                    state_d = spics_pkg::ST_LEAD;
                end else if (slave_ok && slave_fs) begin
                    tsh_d   = tx_valid_i ? tx_data_i : '0;
                    dout_d  = tx_valid_i & tx_data_i[WORD_W-1];
                    doe_d   = 1'b1;
                    state_d = spics_pkg::ST_SLAVE;
                end
            end
            spics_pkg::ST_LEAD: begin
                cnt_d = cnt_q + spics_pkg::CNT_ONE;
                if (phase_done) begin
                    cnt_d   = '0;
                    state_d = spics_pkg::ST_SHIFT;
                end
            end
            spics_pkg::ST_SHIFT: begin
                cnt_d = cnt_q + spics_pkg::CNT_ONE;
                if (phase_done) begin
                    cnt_d     = '0;
                    sck_d     = ~sck_q;
                    edge_hit  = 1'b1;
                    edge_rise = ~sck_q;
                    edges_d   = edges_q + 1'b1;
                    if (edges_q == LAST_EDGE) begin
                        state_d = spics_pkg::ST_TRAIL;
                    end
                end
            end
            spics_pkg::ST_TRAIL: begin
                cnt_d = cnt_q + spics_pkg::CNT_ONE;
                // [R15] enable released, clock parked
                if (phase_done) begin
                    fs_d    = 1'b0;
                    doe_d   = 1'b0;
                    state_d = spics_pkg::ST_IDLE;
                end
            end
            spics_pkg::ST_SLAVE: begin
                edge_hit  = slave_edge & (bits_q != BIT_W'(WORD_W));
                edge_rise = s2_q[spics_pkg::SY_CLK];
                // [R13] release data when enable goes high
                if (!slave_fs) begin
                    doe_d   = 1'b0;
                    edge_hit = 1'b0;
                    state_d = spics_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = spics_pkg::ST_IDLE;
                fs_d    = 1'b0;
                doe_d   = 1'b0;
            end
        endcase
        // [R11] [R12] [R14] sample on one edge, launch on the other
        if (edge_hit) begin
            if (edge_rise == sample_rise) begin
                rsh_d  = {rsh_q[WORD_W-2:0], rxd_in};
                bits_d = bits_q + 1'b1;
                if (bits_q == LAST_BIT) begin
                    rdat_d = {rsh_q[WORD_W-2:0], rxd_in};
                    rval_d = 1'b1;
                end
            end else if (bits_q != '0) begin
                // a launch edge that comes before any sample would drop the top bit, so it is skipped
                tsh_d  = {tsh_q[WORD_W-2:0], 1'b0};
                dout_d = tsh_q[WORD_W-2];
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= spics_pkg::ST_IDLE;
            cnt_q   <= '0;
            edges_q <= '0;
            bits_q  <= '0;
            tsh_q   <= '0;
            rsh_q   <= '0;
            rdat_q  <= '0;
            rval_q  <= 1'b0;
            sck_q   <= 1'b0;
            fs_q    <= 1'b0;
            dout_q  <= 1'b0;
            doe_q   <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            edges_q <= edges_d;
            bits_q  <= bits_d;
            tsh_q   <= tsh_d;
            rsh_q   <= rsh_d;
            rdat_q  <= rdat_d;
            rval_q  <= rval_d;
            sck_q   <= sck_d;
            fs_q    <= fs_d;
            dout_q  <= dout_d;
            doe_q   <= doe_d;
            err_q   <= err_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rx_data_o                 = rdat_q;
    assign rx_valid_o                = rval_q;
    assign mode_error_o              = err_q;
    assign serial_bit_clock_pin_o    = sck_q;
    assign serial_bit_clock_pin_oe_o = master_ok;
    // [R02] frame driven as active-low enable
    assign tx_frame_pin_o            = fs_q ^ cfg_i.tx_frame_polarity;
    assign tx_frame_pin_oe_o         = master_ok;
    assign serial_tx_data_pin_o      = dout_q;
    assign serial_tx_data_pin_oe_o   = doe_q;

endmodule : spics_port
`default_nettype wire

// >>> dv/spics_peer.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// far-side slave model
// ----------------------------------------
module spics_peer #(
    parameter int unsigned WORD_W = 8
) (
    input  wire logic              sclk_i,
    input  wire logic              sel_n_i,
    input  wire logic              sample_rise_i,
    input  wire logic              mosi_i,
    input  wire logic [WORD_W-1:0] word_i,
    output logic                   miso_o,
    output logic [WORD_W-1:0]      got_o
);
    logic [WORD_W-1:0] sh_q = '0;
    logic              rel_q = 1'h0;
    int                n_q = 0;
    // word loaded when enable goes low
    always @(negedge sel_n_i) begin
        sh_q = word_i;
        n_q = 0;
    end
    // sample on one edge, shift on the other
    always @(sclk_i) begin
        if (!sel_n_i && sclk_i == sample_rise_i) begin
            got_o = {got_o[WORD_W-2:0], mosi_i};
            n_q++;
        end else if (!sel_n_i && n_q > 0) begin
            sh_q = sh_q << 1;
        end
    end
    // no pull on the line, so a released line shows the inverse of the last bit
    always @(posedge sel_n_i) rel_q = ~sh_q[WORD_W-1];
    assign miso_o = sel_n_i ? rel_q : sh_q[WORD_W-1];
endmodule : spics_peer
`default_nettype wire

// >>> dv/spics_port_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module spics_port_checker #(
    parameter int unsigned WORD_W = 8
) (
    input wire logic                  mclk_i,
    input wire logic                  nrst_i,
    input wire spics_pkg::spics_cfg_t cfg_i,
    input wire logic                  tx_ready_o,
    input wire logic                  rx_valid_o,
    input wire logic                  mode_error_o,
    input wire logic                  serial_bit_clock_pin_o,
    input wire logic                  serial_bit_clock_pin_oe_o,
    input wire logic                  tx_frame_pin_i,
    input wire logic                  tx_frame_pin_o,
    input wire logic                  tx_frame_pin_oe_o,
    input wire logic                  rx_frame_pin_i,
    input wire logic                  serial_tx_data_pin_oe_o
);
    logic       ms, allz, sl, fr, sen, chg, clk_q, seen_q;
    logic [3:0] dirs;
    logic [8:0] dv, lo, ph, cnt_d, cnt_q;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    assign dirs = {cfg_i.tx_clock_direction, cfg_i.rx_clock_direction, cfg_i.tx_frame_direction,
                   cfg_i.rx_frame_direction};
    assign ms   = cfg_i.clock_stop_phase_select[1] & (dirs == 4'ha);
    assign allz = cfg_i.clock_stop_phase_select[1] & (dirs == 4'h0);
    assign sl   = allz & cfg_i.rate_gen_clock_source & (cfg_i.rate_gen_divide_value == 8'h01);
    assign dv   = {1'h0, cfg_i.rate_gen_divide_value};
    assign fr   = tx_frame_pin_o ^ cfg_i.tx_frame_polarity;
    assign sen  = (tx_frame_pin_i ^ cfg_i.tx_frame_polarity) | (rx_frame_pin_i ^ cfg_i.rx_frame_polarity);
    assign chg  = serial_bit_clock_pin_o != clk_q;
    // phase length counted in cpu cycles since the last clock toggle or frame start
    always_comb begin
        lo    = (dv == 9'h0) ? 9'h1 : (dv[0] ? (dv + 9'h1) >> 1 : dv >> 1);
        ph    = clk_q ? ((dv == 9'h0) ? 9'h1 : dv + 9'h1 - lo) : lo;
        cnt_d = !fr ? 9'h0 : (chg ? 9'h1 : cnt_q + 9'h1);
    end
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clk_q  <= 1'h0;
            cnt_q  <= 9'h0;
            seen_q <= 1'h0;
        end else begin
            clk_q  <= serial_bit_clock_pin_o;
            cnt_q  <= cnt_d;
            seen_q <= fr & (seen_q | chg);
        end
    end
    a_master_drive: assert property (ms |-> serial_bit_clock_pin_oe_o && tx_frame_pin_oe_o)
        else $error("master setup leaves clock or enable undriven");
    a_slave_float: assert property (allz |-> !serial_bit_clock_pin_oe_o && !tx_frame_pin_oe_o)
        else $error("slave setup drives clock or enable");
    a_enable_idle: assert property (ms && cfg_i.tx_frame_polarity && tx_ready_o && $stable(cfg_i) |-> tx_frame_pin_o)
        else $error("idle enable output not high");
    a_enable_lead: assert property ($rose(fr) && ms |-> serial_bit_clock_pin_o == cfg_i.tx_clock_polarity)
        else $error("clock left idle level before enable went active");
    // first toggle also covers the lead phase of the same length before clocking starts
    a_clock_phase: assert property (ms && fr && chg |-> cnt_q == (seen_q ? ph : (ph << 1)))
        else $error("clock phase length wrong");
    a_frame_ends: assert property (ms && rx_valid_o |-> ##[1:300] (!fr && !serial_tx_data_pin_oe_o))
        else $error("frame not closed after last bit");
    a_idle_clock: assert property (ms && !fr && !$past(fr) && $past(nrst_i) && $stable(cfg_i) |-> serial_bit_clock_pin_o == cfg_i.tx_clock_polarity)
        else $error("clock not stopped at idle level");
    a_slave_release: assert property ((allz && !sen) [*5] |-> !serial_tx_data_pin_oe_o)
        else $error("slave data line still driven after enable released");
    a_slave_ready: assert property ((allz && !sen) [*5] |-> !tx_ready_o)
        else $error("slave ready without active enable");
    a_slave_rate: assert property (allz && !sl ##1 $stable(cfg_i) |-> mode_error_o)
        else $error("bad slave rate setup not flagged");
    c_master_word: cover property (ms && rx_valid_o);
    c_slave_word: cover property (sl && rx_valid_o);
    c_mode_error: cover property (mode_error_o);
endmodule : spics_port_checker
bind spics_port spics_port_checker #(.WORD_W(WORD_W)) u_checker (
    .mclk_i, .nrst_i, .cfg_i, .tx_ready_o, .rx_valid_o, .mode_error_o, .serial_bit_clock_pin_o,
    .serial_bit_clock_pin_oe_o, .tx_frame_pin_i, .tx_frame_pin_o, .tx_frame_pin_oe_o, .rx_frame_pin_i,
    .serial_tx_data_pin_oe_o
);
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// bench
// ----------------------------------------
module tb_top;
    localparam int unsigned W = 8;
    logic                  mclk = 1'h0;
    logic                  nrst = 1'h0;
    spics_pkg::spics_cfg_t cfg = '0;
    logic [W-1:0]          tx_data = '0;
    logic                  tx_valid = 1'h0;
    logic                  m_ck = 1'h1;
    logic                  m_fs = 1'h1;
    logic                  m_dq = 1'h0;
    logic                  m_sel = 1'h0;
    logic                  p_rise = 1'h0;
    logic [W-1:0]          p_word = '0;
    logic [W-1:0]          rx_data, p_got;
    logic                  tx_ready, rx_valid, mode_err, ck_o, ck_oe, fs_o, fs_oe, dq_o, dq_oe, p_dq;
    int                    mismatches = 0;
    int                    checks_done = 0;
    int                    cyc = 0;
    wire logic             ck_w = ck_oe ? ck_o : m_ck;
    wire logic             fs_w = fs_oe ? fs_o : m_fs;
    wire logic             dq_in = m_sel ? m_dq : p_dq;
    always #2 mclk = ~mclk;
    spics_port #(.WORD_W(W)) DUT (
        .mclk_i(mclk), .nrst_i(nrst), .cfg_i(cfg), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
        .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .mode_error_o(mode_err),
        .serial_bit_clock_pin_i(ck_w), .serial_bit_clock_pin_o(ck_o), .serial_bit_clock_pin_oe_o(ck_oe),
        .tx_frame_pin_i(fs_w), .tx_frame_pin_o(fs_o), .tx_frame_pin_oe_o(fs_oe), .rx_frame_pin_i(1'h1),
        .serial_tx_data_pin_o(dq_o), .serial_tx_data_pin_oe_o(dq_oe), .serial_rx_data_pin_i(dq_in)
    );
    spics_peer #(.WORD_W(W)) u_peer (
        .sclk_i(ck_w), .sel_n_i(fs_w), .sample_rise_i(p_rise), .mosi_i(dq_o), .word_i(p_word),
        .miso_o(p_dq), .got_o(p_got)
    );
    task automatic cmp(input string what, input logic [W-1:0] exp, input logic [W-1:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    // bounded wait for the received-word pulse or the end of the frame
    task automatic wait_until(input logic frame_end);
        int i;
        for (i = 0; i < 800; i++) begin
            @(negedge mclk);
            if (frame_end ? fs_o === 1'h1 : rx_valid === 1'h1) break;
        end
        cmp("wait", 1'h1, i < 800);
    endtask : wait_until
    task automatic t_master(input logic [1:0] stop, input logic pol, input logic [7:0] div,
                            input logic [W-1:0] d, input logic [W-1:0] pw, input logic chk_in);
        @(negedge mclk);
        cfg = {stop, pol, 1'h1, div, 2'h3, 4'ha};
        p_word = pw;
        p_rise = pol ^ stop[0];
        m_sel = 1'h0;
        repeat (3) @(negedge mclk);
        cmp("clock oe", 1'h1, ck_oe);
        cmp("enable idle", 1'h1, fs_o);
        cmp("idle clock", pol, ck_o);
        cmp("ready", 1'h1, tx_ready);
        tx_data = d;
        tx_valid = 1'h1;
        @(negedge mclk);
        tx_valid = 1'h0;
        @(negedge mclk);
        cmp("enable active", 1'h0, fs_o);
        cmp("lead clock", pol, ck_o);
        wait_until(1'h0);
        // fast divides outrun the input synchroniser, so only outbound data is judged there
        if (chk_in) cmp("master rx", pw, rx_data);
        wait_until(1'h1);
        cmp("peer rx", d, p_got);
        cmp("data released", 1'h0, dq_oe);
        $display("master test done stop %b pol %b div %0d", stop, pol, div);
    endtask : t_master
    task automatic t_slave(input logic [W-1:0] d, input logic [W-1:0] mw);
        int i;
        logic [W-1:0] got;
        @(negedge mclk);
        m_sel = 1'h1;
        cfg = {2'h2, 1'h1, 1'h1, 8'h02, 2'h3, 4'h0};
        repeat (3) @(negedge mclk);
        cmp("mode error", 1'h1, mode_err);
        cmp("slave clock oe", 1'h0, ck_oe);
        cfg.rate_gen_divide_value = 8'h01;
        tx_data = d;
        tx_valid = 1'h1;
        repeat (3) @(negedge mclk);
        cmp("mode ok", 1'h0, mode_err);
        cmp("ready without enable", 1'h0, tx_ready);
        m_fs = 1'h0;
        repeat (8) @(negedge mclk);
        tx_valid = 1'h0;
        cmp("slave drives", 1'h1, dq_oe);
        for (i = 0; i < W; i++) begin
            m_ck = 1'h0;
            m_dq = mw[W-1-i];
            repeat (8) @(negedge mclk);
            m_ck = 1'h1;
            got = {got[W-2:0], dq_o};
            repeat (8) @(negedge mclk);
        end
        cmp("slave rx", mw, rx_data);
        cmp("slave tx", d, got);
        m_fs = 1'h1;
        m_dq = ~m_dq;
        repeat (6) @(negedge mclk);
        cmp("slave released", 1'h0, dq_oe);
        $display("slave test done");
    endtask : t_slave
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            $display("[ERR] run length expected done seen hang");
            finish_test();
        end
    end
    initial begin
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        nrst = 1'h1;
        t_master(2'h2, 1'h1, 8'h07, 8'ha5, 8'h3c, 1'h1);
        t_master(2'h3, 1'h1, 8'h08, 8'h81, 8'h7e, 1'h1);
        t_master(2'h2, 1'h0, 8'h06, 8'h5a, 8'hc3, 1'h1);
        t_master(2'h3, 1'h0, 8'h05, 8'hf0, 8'h0f, 1'h1);
        t_master(2'h2, 1'h1, 8'h00, 8'h96, 8'h69, 1'h0);
        t_slave(8'hc6, 8'h39);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
